// [rtl/vtc_map.svh]
`ifndef VTC_MAP_SVH
`define VTC_MAP_SVH
// Internal register indices behind the address pointer
`define VTC_REG_FILL_LO 4'h0
`define VTC_REG_FILL_HI 4'h1
`define VTC_REG_TOS_LO 4'h2
`define VTC_REG_TOS_HI 4'h3
`define VTC_REG_CUR_LO 4'h4
`define VTC_REG_CUR_HI 4'h5
`define VTC_REG_ATTR 4'h6
`define VTC_REG_MODE 4'h7
`define VTC_REG_CHAR 4'h8
`define VTC_REG_CADDR_LO 4'h9
`define VTC_REG_CADDR_HI 4'ha
// Field positions
`define VTC_MODE_AUTOINC 0
`define VTC_MODE_FILL 1
`define VTC_ATTR_INTENS 0
`define VTC_STAT_DONE 7
// Reset values
`define VTC_MODE_RESET 8'h00
`define VTC_ATTR_RESET 8'h00
// Timing defaults
`define VTC_PRESCALE 2
`define VTC_DOTS 8
`define VTC_HTOT 100
`define VTC_HVIS 80
`define VTC_HSS 84
`define VTC_HSW 8
`define VTC_SCANS 10
`define VTC_VTOT 262
`define VTC_VVIS 240
`define VTC_VSS 245
`define VTC_VSW 3
`endif

// [rtl/vtc_pkg.sv]
package vtc_pkg;
    typedef enum logic [1:0] {
        MA_IDLE = 2'b00,
        MA_WRITE = 2'b01,
        MA_READ = 2'b10
    } mem_access_type;
endpackage

// [rtl/video_terminal_controller.sv]
// Overview of operation
// - Dot clock enable comes from a prescaler of the crystal input.
// - Character clock pulses once every programmed number of dot clocks.
// - Dot-rate shift register serialises each cell's pixel row to video.
// - Timing counters make line, frame and combined sync.
// - Combined sync is line XOR frame sync, usable for composite video.
// - Memory writes happen in line blanking with an active-low write strobe.
// - Each frame the screen counter loads the start address and walks one screen.
// - Cursor flag set when screen counter equals cursor address.
// - Fill writes successive cells and stops before the fill end address.
// - Character access counter addresses host-initiated memory transfers.
// - Address mux picks refresh counter or character access counter.
// - Memory address is 11 bits, memory data bus 8 bits two-way.
// - Host data moves only while host strobe is low, direction by the read/write line.
// - Video output is active low: high black, low white.
// - Intensity output is aligned with the pixels it modifies.
// - Font ROM gets a 16-bit address and returns 8 pixel bits.
// - Writing the address pointer selects the register for the next data access.
// - Status bit 7 reports the character transfer as done.
// - Auto-increment advances the character address, not the cursor.
`include "vtc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module video_terminal_controller #(
    parameter int PRESCALE = `VTC_PRESCALE,
    parameter int DOTS = `VTC_DOTS,
    parameter int HTOT = `VTC_HTOT,
    parameter int HVIS = `VTC_HVIS,
    parameter int HSS = `VTC_HSS,
    parameter int HSW = `VTC_HSW,
    parameter int SCANS = `VTC_SCANS,
    parameter int VTOT = `VTC_VTOT,
    parameter int VVIS = `VTC_VVIS,
    parameter int VSS = `VTC_VSS,
    parameter int VSW = `VTC_VSW
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic crystal_in_i,
    input wire logic host_strobe_n_i,
    input wire logic host_rw_i,
    input wire logic host_sel_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic [10:0] display_mem_addr_o,
    input wire logic [7:0] display_data_bus_i,
    output logic [7:0] display_data_bus_o,
    output logic display_data_bus_oe_o,
    output logic display_write_n_o,
    output logic [15:0] font_rom_addr_o,
    input wire logic [7:0] font_rom_data_i,
    output logic line_sync_out_o,
    output logic frame_sync_out_o,
    output logic combined_sync_out_o,
    output logic video_n_o,
    output logic intensity_out_o
);
    import vtc_pkg::*;

    // Two-flop synchronisers for every pin input except clock and reset
    logic [2:0] xtal_s_r;
    logic [1:0] strb_s_r, rw_s_r, sel_s_r;
    logic [7:0] hd_m_r, hd_s_r, dd_m_r, dd_s_r, rom_m_r, rom_s_r;
    logic strb_d_r;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            xtal_s_r <= 3'h0;
            strb_s_r <= 2'h3;
            strb_d_r <= 1'b1;
            rw_s_r <= 2'h3;
            sel_s_r <= 2'h0;
            {hd_m_r, hd_s_r, dd_m_r, dd_s_r, rom_m_r, rom_s_r} <= 48'h0;
        end else begin
            xtal_s_r <= {xtal_s_r[1:0], crystal_in_i};
            strb_s_r <= {strb_s_r[0], host_strobe_n_i};
            strb_d_r <= strb_s_r[1];
            rw_s_r <= {rw_s_r[0], host_rw_i};
            sel_s_r <= {sel_s_r[0], host_sel_i};
            {hd_m_r, hd_s_r} <= {host_data_bus_i, hd_m_r};
            {dd_m_r, dd_s_r} <= {display_data_bus_i, dd_m_r};
            {rom_m_r, rom_s_r} <= {font_rom_data_i, rom_m_r};
        end
    end

    // Dot and character dividers
    logic [7:0] pre_r, dot_r;
    logic [7:0] h_r;
    logic [3:0] s_r;
    logic [9:0] v_r;
    wire xtal_rise = xtal_s_r[1] & ~xtal_s_r[2];
    wire dot_en = xtal_rise && (pre_r == 8'(PRESCALE - 1));
    wire char_tick = dot_en && (dot_r == 8'(DOTS - 1));
    wire line_end = char_tick && (h_r == 8'(HTOT - 1));
    wire frame_start = line_end && (v_r == 10'(VTOT - 1));
    wire h_vis = h_r < 8'(HVIS);
    wire v_vis = v_r < 10'(VVIS);
    wire fetch = char_tick && h_vis && v_vis;
    wire hs_w = (h_r >= 8'(HSS)) && (h_r < 8'(HSS + HSW));
    wire vs_w = (v_r >= 10'(VSS)) && (v_r < 10'(VSS + VSW));
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_r <= 8'h0;
            dot_r <= 8'h0;
            h_r <= 8'h0;
            s_r <= 4'h0;
            v_r <= 10'h0;
        end else begin
            if (xtal_rise) begin
                pre_r <= dot_en ? 8'h0 : pre_r + 8'h1;
            end
            if (dot_en) begin
                dot_r <= char_tick ? 8'h0 : dot_r + 8'h1;
            end
            if (char_tick) begin
                h_r <= line_end ? 8'h0 : h_r + 8'h1;
            end
            if (line_end) begin
                v_r <= frame_start ? 10'h0 : v_r + 10'h1;
                s_r <= (frame_start || s_r == 4'(SCANS - 1)) ? 4'h0 : s_r + 4'h1;
            end
        end
    end

    // Host registers and memory access sequencer
    logic [3:0] ptr_r;
    logic [10:0] fill_end_r, tos_r, cur_r, caddr_r, disp_r, row_r;
    logic [7:0] attr_r, mode_r, cdata_r;
    logic wr_pend_r, rd_pend_r, fill_r;
    mem_access_type ma_r;
    wire strobe_fall = strb_d_r & ~strb_s_r[1];
    wire host_wr = strobe_fall & ~rw_s_r[1];
    wire host_rd = strobe_fall & rw_s_r[1];
    wire data_wr = host_wr & ~sel_s_r[1];
    wire char_wr = data_wr && ptr_r == `VTC_REG_CHAR;
    wire char_rd = host_rd && ~sel_s_r[1] && ptr_r == `VTC_REG_CHAR;
    wire auto_inc = mode_r[`VTC_MODE_AUTOINC];
    wire [10:0] caddr_inc = caddr_r + 11'h1;
    wire done = ~wr_pend_r & ~rd_pend_r & (ma_r == MA_IDLE);
    wire access_win = char_tick && !h_vis && h_r < 8'(HTOT - 2);
    wire ma_end = char_tick && ma_r != MA_IDLE;
    wire fill_more = fill_r && caddr_inc != fill_end_r;
    wire [10:0] mux_addr = (ma_r != MA_IDLE) ? caddr_r : disp_r;
    logic [7:0] rd_data;
    always_comb begin
        unique case (ptr_r)
            `VTC_REG_FILL_LO: rd_data = fill_end_r[7:0];
            `VTC_REG_FILL_HI: rd_data = {5'h0, fill_end_r[10:8]};
            `VTC_REG_TOS_LO: rd_data = tos_r[7:0];
            `VTC_REG_TOS_HI: rd_data = {5'h0, tos_r[10:8]};
            `VTC_REG_CUR_LO: rd_data = cur_r[7:0];
            `VTC_REG_CUR_HI: rd_data = {5'h0, cur_r[10:8]};
            `VTC_REG_ATTR: rd_data = attr_r;
            `VTC_REG_MODE: rd_data = mode_r;
            `VTC_REG_CHAR: rd_data = cdata_r;
            `VTC_REG_CADDR_LO: rd_data = caddr_r[7:0];
            `VTC_REG_CADDR_HI: rd_data = {5'h0, caddr_r[10:8]};
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_r <= 4'h0;
            {fill_end_r, tos_r, cur_r} <= 33'h0;
            attr_r <= `VTC_ATTR_RESET;
            mode_r <= `VTC_MODE_RESET;
            host_data_bus_o <= 8'h00;
            host_data_bus_oe_o <= 1'b0;
        end else begin
            host_data_bus_oe_o <= ~strb_s_r[1] & rw_s_r[1];
            if (host_rd) begin
                host_data_bus_o <= sel_s_r[1] ? {done, 7'h0} : rd_data;
            end
            if (host_wr && sel_s_r[1]) begin
                ptr_r <= hd_s_r[3:0];
            end
            if (data_wr) begin
                unique case (ptr_r)
                    `VTC_REG_FILL_LO: fill_end_r[7:0] <= hd_s_r;
                    `VTC_REG_FILL_HI: fill_end_r[10:8] <= hd_s_r[2:0];
                    `VTC_REG_TOS_LO: tos_r[7:0] <= hd_s_r;
                    `VTC_REG_TOS_HI: tos_r[10:8] <= hd_s_r[2:0];
                    `VTC_REG_CUR_LO: cur_r[7:0] <= hd_s_r;
                    `VTC_REG_CUR_HI: cur_r[10:8] <= hd_s_r[2:0];
                    `VTC_REG_ATTR: attr_r <= hd_s_r;
                    `VTC_REG_MODE: mode_r <= hd_s_r;
                    default: ;
                endcase
            end
        end
    end

    // Character transfers run in line blanking so refresh never stalls
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ma_r <= MA_IDLE;
            caddr_r <= 11'h0;
            cdata_r <= 8'h00;
            {wr_pend_r, rd_pend_r, fill_r} <= 3'h0;
        end else begin
            if (ma_end) begin
                ma_r <= MA_IDLE;
                if (ma_r == MA_READ) begin
                    cdata_r <= dd_s_r;
                    rd_pend_r <= 1'b0;
                end else begin
                    wr_pend_r <= fill_more;
                    fill_r <= fill_more;
                    if (auto_inc || fill_r) begin
                        caddr_r <= caddr_inc;
                    end
                end
            end else if (access_win && (wr_pend_r || rd_pend_r)) begin
                ma_r <= wr_pend_r ? MA_WRITE : MA_READ;
            end
            if (char_wr) begin
                cdata_r <= hd_s_r;
                wr_pend_r <= 1'b1;
                fill_r <= mode_r[`VTC_MODE_FILL];
            end else if (char_rd && auto_inc) begin
                caddr_r <= caddr_inc;
                rd_pend_r <= 1'b1;
            end else if (data_wr && ptr_r == `VTC_REG_CADDR_LO) begin
                caddr_r[7:0] <= hd_s_r;
                rd_pend_r <= 1'b1;
            end else if (data_wr && ptr_r == `VTC_REG_CADDR_HI) begin
                caddr_r[10:8] <= hd_s_r[2:0];
                rd_pend_r <= 1'b1;
            end
        end
    end

    // Screen refresh counter and pixel pipeline
    logic [7:0] code_r, shift_r;
    logic curs_r, fv_r, vis_r, int_r;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            disp_r <= 11'h0;
            row_r <= 11'h0;
            {code_r, shift_r} <= 16'h0;
            {curs_r, fv_r, vis_r, int_r} <= 4'h0;
        end else begin
            if (frame_start) begin
                disp_r <= tos_r;
                row_r <= tos_r;
            end else if (line_end && v_vis) begin
                if (s_r == 4'(SCANS - 1)) begin
                    row_r <= disp_r;
                end else begin
                    disp_r <= row_r;
                end
            end else if (fetch) begin
                disp_r <= disp_r + 11'h1;
            end
            if (char_tick) begin
                code_r <= dd_s_r;
                curs_r <= fetch && disp_r == cur_r;
                fv_r <= fetch;
                vis_r <= fv_r;
                int_r <= fv_r & attr_r[`VTC_ATTR_INTENS];
            end
            if (dot_en) begin
                shift_r <= char_tick ? (rom_s_r ^ {8{curs_r}}) : {shift_r[6:0], 1'b0};
            end
        end
    end

    // Registered pin drivers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            display_mem_addr_o <= 11'h0;
            display_data_bus_o <= 8'h00;
            display_data_bus_oe_o <= 1'b0;
            display_write_n_o <= 1'b1;
            font_rom_addr_o <= 16'h0;
            {line_sync_out_o, frame_sync_out_o, combined_sync_out_o} <= 3'h0;
            video_n_o <= 1'b1;
            intensity_out_o <= 1'b0;
        end else begin
            display_mem_addr_o <= mux_addr;
            display_data_bus_o <= cdata_r;
            display_data_bus_oe_o <= ma_r == MA_WRITE;
            display_write_n_o <= ma_r != MA_WRITE;
            font_rom_addr_o <= {4'h0, code_r, s_r};
            line_sync_out_o <= hs_w;
            frame_sync_out_o <= vs_w;
            combined_sync_out_o <= hs_w ^ vs_w;
            video_n_o <= ~(vis_r & shift_r[7]);
            intensity_out_o <= vis_r & int_r;
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_dot_gap;
        dot_en |=> !dot_en;
    endproperty
    a_dot_gap: assert property (p_dot_gap) else $error("dot enable back to back");
    property p_char_on_dot;
        char_tick |-> dot_en && dot_r == 8'(DOTS - 1);
    endproperty
    a_char_on_dot: assert property (p_char_on_dot) else $error("char tick off dot");
    property p_csync;
        ##1 combined_sync_out_o == (line_sync_out_o ^ frame_sync_out_o);
    endproperty
    a_csync: assert property (p_csync) else $error("combined sync mismatch");
    property p_write_strobe;
        ma_r == MA_WRITE |=> !display_write_n_o && display_data_bus_oe_o;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("write strobe missing");
    property p_frame_load;
        frame_start |=> disp_r == $past(tos_r);
    endproperty
    a_frame_load: assert property (p_frame_load) else $error("frame start load wrong");
    property p_cursor;
        fetch && disp_r == cur_r |=> curs_r;
    endproperty
    a_cursor: assert property (p_cursor) else $error("cursor not flagged");
    property p_fill_stop;
        ma_end && ma_r == MA_WRITE && fill_r && caddr_inc == fill_end_r |=> !fill_r && !wr_pend_r;
    endproperty
    a_fill_stop: assert property (p_fill_stop) else $error("fill ran past end");
    property p_mux;
        ma_r != MA_IDLE |=> display_mem_addr_o == $past(caddr_r);
    endproperty
    a_mux: assert property (p_mux) else $error("address mux wrong");
    property p_host_oe;
        host_data_bus_oe_o |-> $past(!strb_s_r[1] && rw_s_r[1]);
    endproperty
    a_host_oe: assert property (p_host_oe) else $error("host bus driven outside read strobe");
    property p_black;
        !vis_r |=> video_n_o;
    endproperty
    a_black: assert property (p_black) else $error("video not black in blanking");
    property p_wrap;
        fetch && !frame_start && !(line_end && v_vis) && disp_r == 11'h7ff |=> disp_r == 11'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("screen counter did not wrap");
endmodule
`default_nettype wire

// [verif/vtc_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vtc_mem_model (
    input wire logic ref_clk_i,
    input wire logic [10:0] display_mem_addr_i,
    input wire logic [7:0] display_data_bus_i,
    input wire logic display_data_bus_oe_i,
    input wire logic display_write_n_i,
    output logic [7:0] display_data_bus_o,
    input wire logic [15:0] font_rom_addr_i,
    output logic [7:0] font_rom_data_o
);
    logic [7:0] ram [0:2047];
    initial begin
        for (int i = 0; i < 2048; i++) begin
            ram[i] = 8'h00;
        end
    end
    // Shared wire: device data while it drives, else the addressed RAM byte
    assign display_data_bus_o = display_data_bus_oe_i ? display_data_bus_i : ram[display_mem_addr_i];
    always @(posedge ref_clk_i) begin
        if (display_write_n_i == 1'b0) begin
            ram[display_mem_addr_i] <= display_data_bus_o;
        end
    end
    // Code 0 blank, others solid; stray upper address bits give a solid row
    assign font_rom_data_o = (font_rom_addr_i[11:4] == 8'h00 && font_rom_addr_i[15:12] == 4'h0) ? 8'h00 : 8'hff;
endmodule
`default_nettype wire

// [verif/video_terminal_controller_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "vtc_map.svh"
module video_terminal_controller_tb;
    import vtc_pkg::*;
    // Crystal rise every two clocks, prescale x dots rises per cell
    localparam int CHAR_CYC = 2 * `VTC_PRESCALE * `VTC_DOTS;
    // Default line timing, short frame so a whole frame fits the run
    localparam int SIM_LINES = 4;
    localparam int LINE_CYC = `VTC_HTOT * CHAR_CYC;
    localparam int FRAME_CYC = SIM_LINES * LINE_CYC;
    logic ref_clk_i = 0, rst_i = 1, crystal_in_i = 0, host_strobe_n_i = 1, host_rw_i = 0, host_sel_i = 0;
    logic [7:0] host_drv = 8'h00, host_data_bus_i, host_data_bus_o, display_data_bus_o, display_data_bus_i, font_rom_data_i;
    logic host_data_bus_oe_o, display_data_bus_oe_o, display_write_n_o, line_sync_out_o, frame_sync_out_o;
    logic combined_sync_out_o, video_n_o, intensity_out_o, ls_prev = 0, fs_prev = 0, w_oe, mon_on = 0;
    logic [10:0] display_mem_addr_o, w_addr;
    logic [15:0] font_rom_addr_o;
    logic [7:0] w_data, rd;
    int n_errors = 0, cmp_count = 0, cyc = 0, wlen = 0, wlen_done = 0, ls_last = -1, ls_hi = 0;
    int vlow = 0, vlow_dim = 0, bad_sync = 0, bad_rom = 0, bad_per = 0, bad_wid = 0, fs_rise = 0;
    assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : host_drv;
    video_terminal_controller #(.VTOT(SIM_LINES), .VVIS(2), .VSS(2), .VSW(1)) uut (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .crystal_in_i(crystal_in_i),
        .host_strobe_n_i(host_strobe_n_i), .host_rw_i(host_rw_i), .host_sel_i(host_sel_i),
        .host_data_bus_i(host_data_bus_i), .host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
        .display_mem_addr_o(display_mem_addr_o), .display_data_bus_i(display_data_bus_i),
        .display_data_bus_o(display_data_bus_o), .display_data_bus_oe_o(display_data_bus_oe_o),
        .display_write_n_o(display_write_n_o), .font_rom_addr_o(font_rom_addr_o), .font_rom_data_i(font_rom_data_i),
        .line_sync_out_o(line_sync_out_o), .frame_sync_out_o(frame_sync_out_o),
        .combined_sync_out_o(combined_sync_out_o), .video_n_o(video_n_o), .intensity_out_o(intensity_out_o));
    vtc_mem_model mem (.ref_clk_i(ref_clk_i), .display_mem_addr_i(display_mem_addr_o),
        .display_data_bus_i(display_data_bus_o), .display_data_bus_oe_i(display_data_bus_oe_o),
        .display_write_n_i(display_write_n_o), .display_data_bus_o(display_data_bus_i),
        .font_rom_addr_i(font_rom_addr_o), .font_rom_data_o(font_rom_data_i));
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        #1 crystal_in_i = ~crystal_in_i;
    end
    // Outputs are sampled before the edge's own updates land
    always @(posedge ref_clk_i) begin
        if (display_write_n_o === 1'b0) begin
            wlen++;
            w_addr = display_mem_addr_o;
            w_data = display_data_bus_o;
            w_oe = display_data_bus_oe_o;
        end else if (wlen > 0) begin
            wlen_done = wlen;
            wlen = 0;
        end
        // Pulse width counted always, so a window opening mid-pulse is not short
        if (line_sync_out_o === 1'b1) ls_hi++;
        if (mon_on) begin
            if (video_n_o === 1'b0) vlow++;
            if (video_n_o === 1'b0 && intensity_out_o !== 1'b1) vlow_dim++;
            if (combined_sync_out_o !== (line_sync_out_o ^ frame_sync_out_o)) bad_sync++;
            if (font_rom_addr_o[15:12] !== 4'h0) bad_rom++;
            if (line_sync_out_o === 1'b1 && ls_prev === 1'b0) begin
                if (ls_last >= 0 && cyc - ls_last != LINE_CYC) bad_per++;
                ls_last = cyc;
            end
            if (line_sync_out_o === 1'b0 && ls_prev === 1'b1 && ls_hi != `VTC_HSW * CHAR_CYC) bad_wid++;
            if (frame_sync_out_o === 1'b1 && fs_prev === 1'b0) fs_rise++;
        end
        if (line_sync_out_o === 1'b0) ls_hi = 0;
        ls_prev = line_sync_out_o;
        fs_prev = frame_sync_out_o;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    // Strobe held 8 clocks each way, well above the synchroniser latency
    task automatic host_wr(input logic sel, input logic [7:0] d);
        @(posedge ref_clk_i) #1;
        host_sel_i = sel;
        host_rw_i = 1'b0;
        host_drv = d;
        host_strobe_n_i = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1 host_strobe_n_i = 1'b1;
        host_drv = ~d;
        repeat (8) @(posedge ref_clk_i);
    endtask
    task automatic host_rd(input logic sel, output logic [7:0] d);
        @(posedge ref_clk_i) #1;
        host_sel_i = sel;
        host_rw_i = 1'b1;
        host_strobe_n_i = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        chk("host oe", 16'h1, {15'h0, host_data_bus_oe_o});
        d = host_data_bus_o;
        #1 host_strobe_n_i = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk("host oe off", 16'h0, {15'h0, host_data_bus_oe_o});
    endtask
    task automatic reg_wr(input logic [3:0] idx, input logic [7:0] d);
        host_wr(1'b1, {4'h0, idx});
        host_wr(1'b0, d);
    endtask
    task automatic wait_done();
        logic [7:0] s;
        // Transfers wait for line blanking, so allow more than one full line
        for (int i = 0; i < 300; i++) begin
            host_rd(1'b1, s);
            if (s[7] === 1'b1) return;
        end
        $display("unexpected status done: expected 1 seen 0");
        n_errors++;
        summarize();
    endtask
    task automatic t_screen(input logic [10:0] tos, input logic [10:0] cur, input logic lit);
        logic low_seen;
        logic rose;
        reg_wr(`VTC_REG_TOS_LO, tos[7:0]);
        reg_wr(`VTC_REG_TOS_HI, {5'h0, tos[10:8]});
        reg_wr(`VTC_REG_CUR_LO, cur[7:0]);
        reg_wr(`VTC_REG_CUR_HI, {5'h0, cur[10:8]});
        low_seen = 1'b0;
        rose = 1'b0;
        // Window opens on a frame sync rise, so the next frame carries the new start
        for (int i = 0; i < 2 * FRAME_CYC && !rose; i++) begin
            @(posedge ref_clk_i) #1;
            rose = low_seen && frame_sync_out_o === 1'b1;
            low_seen = low_seen || frame_sync_out_o === 1'b0;
        end
        if (!rose) begin
            $display("unexpected frame sync rise: expected 1 seen 0");
            n_errors++;
            summarize();
        end
        vlow = 0;
        vlow_dim = 0;
        ls_last = -1;
        fs_rise = 0;
        mon_on = 1;
        repeat (FRAME_CYC) @(posedge ref_clk_i);
        #1 mon_on = 0;
        chk("cursor pixels", {15'h0, lit}, {15'h0, vlow > 0});
        chk("dim pixels", 16'h0, vlow_dim[15:0]);
        chk("combined sync", 16'h0, bad_sync[15:0]);
        chk("font addr top", 16'h0, bad_rom[15:0]);
        chk("line period", 16'h0, bad_per[15:0]);
        chk("line width", 16'h0, bad_wid[15:0]);
        chk("frame syncs", 16'h1, fs_rise[15:0]);
    endtask
    task automatic t_write();
        reg_wr(`VTC_REG_MODE, 8'h00);
        reg_wr(`VTC_REG_CADDR_LO, 8'h20);
        reg_wr(`VTC_REG_CADDR_HI, 8'h00);
        wait_done();
        reg_wr(`VTC_REG_CHAR, 8'h5a);
        wait_done();
        repeat (4) @(posedge ref_clk_i);
        chk("ram 020", 16'h5a, {8'h0, mem.ram[11'h020]});
        chk("write len", CHAR_CYC, wlen_done[15:0]);
        chk("write addr", 16'h020, {5'h0, w_addr});
        chk("write data", 16'h5a, {8'h0, w_data});
        chk("write oe", 16'h1, {15'h0, w_oe});
    endtask
    task automatic t_autoinc();
        reg_wr(`VTC_REG_MODE, 8'h01);
        reg_wr(`VTC_REG_CADDR_LO, 8'h30);
        wait_done();
        reg_wr(`VTC_REG_CHAR, 8'h11);
        wait_done();
        reg_wr(`VTC_REG_CHAR, 8'h22);
        wait_done();
        chk("ram 030", 16'h11, {8'h0, mem.ram[11'h030]});
        chk("ram 031", 16'h22, {8'h0, mem.ram[11'h031]});
        reg_wr(`VTC_REG_CADDR_LO, 8'h30);
        wait_done();
        host_wr(1'b1, {4'h0, `VTC_REG_CHAR});
        host_rd(1'b0, rd);
        chk("char read", 16'h11, {8'h0, rd});
    endtask
    task automatic t_fill();
        reg_wr(`VTC_REG_MODE, 8'h02);
        reg_wr(`VTC_REG_FILL_LO, 8'h04);
        reg_wr(`VTC_REG_FILL_HI, 8'h01);
        reg_wr(`VTC_REG_CADDR_LO, 8'h00);
        reg_wr(`VTC_REG_CADDR_HI, 8'h01);
        wait_done();
        reg_wr(`VTC_REG_CHAR, 8'h77);
        wait_done();
        for (int i = 0; i < 5; i++) begin
            chk("fill cell", (i < 4) ? 16'h77 : 16'h00, {8'h0, mem.ram[11'h100 + i]});
        end
        host_wr(1'b1, {4'h0, `VTC_REG_FILL_LO});
        host_rd(1'b0, rd);
        chk("fill end read", 16'h04, {8'h0, rd});
    endtask
    task automatic t_reset();
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk("reset write_n", 16'h1, {15'h0, display_write_n_o});
        chk("reset video_n", 16'h1, {15'h0, video_n_o});
        chk("reset oe", 16'h0, {14'h0, host_data_bus_oe_o, display_data_bus_oe_o});
        chk("reset syncs", 16'h0, {13'h0, line_sync_out_o, frame_sync_out_o, combined_sync_out_o});
        @(posedge ref_clk_i) #1 rst_i = 1'b0;
    endtask
    initial begin
        t_reset();
        reg_wr(`VTC_REG_ATTR, 8'h01);
        t_screen(11'h400, 11'h001, 1'b0);
        t_screen(11'h7fc, 11'h001, 1'b1);
        t_write();
        t_autoinc();
        t_fill();
        summarize();
    end
endmodule
`default_nettype wire
